// file: pmc_consts.svh
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH
`define PMC_ADDR_W 8
`define PMC_CTRL_OFS 8'h00
`define PMC_VREG_OFS 8'h04
`define PMC_STAT_OFS 8'h08
`define PMC_CFG_OFS 8'h0C
`define PMC_CTRL_IDLE_BIT 7
`define PMC_CTRL_DOZE_BIT 6
`define PMC_CTRL_ROI_BIT 5
`define PMC_CTRL_DOE_BIT 4
`define PMC_VREG_LP_BIT 1
`define PMC_VREG_ONE_BIT 0
`define PMC_STAT_TO_BIT 4
`define PMC_STAT_PD_BIT 3
`define PMC_CFG_XTAL_BIT 0
`define PMC_CFG_WSLP_BIT 1
`define PMC_RESP_OKAY 2'h0
`define PMC_RESP_SLVERR 2'h2
`define PMC_REF_PERIOD_NS 10
`define PMC_OST_PERIODS 1024
`define PMC_OST_CYC (`PMC_OST_PERIODS)
`define PMC_VREG_STAB_NS 2000
`define PMC_VREG_STAB_CYC ((`PMC_VREG_STAB_NS + `PMC_REF_PERIOD_NS - 1) / `PMC_REF_PERIOD_NS)
`endif

// file: pmc_pkg.sv
package pmc_pkg;
	typedef enum logic [2:0] {
		PMC_RUN = 3'h0,
		PMC_IDLE = 3'h1,
		PMC_SLEEP = 3'h2,
		PMC_OST = 3'h3,
		PMC_STAB = 3'h4
	} pmc_state_e_t;

	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} pmc_axi_in_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} pmc_axi_out_t;

	typedef struct packed {
		logic sleep_exec;
		logic isr_entry;
		logic isr_return;
		logic int_pending;
		logic global_int_enable;
		logic wdt_timeout;
	} pmc_cpu_in_t;

	typedef struct packed {
		logic cpu_run;
		logic sys_clk_en;
		logic slow_osc_en;
		logic io_hold;
		logic reg_low_power;
		logic wdt_run;
		logic wdt_clear;
		logic wdt_reset;
		logic prefetch;
		logic vector_req;
		logic resume;
	} pmc_ctl_out_t;

	typedef struct packed {
		pmc_state_e_t st;
		logic [7:0] cnt;
		logic [11:0] wcnt;
		logic idle;
		logic doze;
		logic recover_on_interrupt;
		logic doze_on_exit;
		logic [2:0] ratio;
		logic vreg;
		logic xtal;
		logic wdt_slp;
		logic pd;
		logic to;
		logic wake_int;
		logic aw_have;
		logic [7:0] aw_addr;
		logic w_have;
		logic [7:0] w_data;
		logic w_strb0;
		pmc_axi_out_t axo;
		pmc_ctl_out_t ctl;
	} pmc_state_t;
endpackage

// file: pmc_top.sv
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pmc_consts.svh"
module pmc_top import pmc_pkg::*; (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire pmc_axi_in_t axi_in,
	output pmc_axi_out_t axi_out,
	input wire pmc_cpu_in_t cpu_in,
	output pmc_ctl_out_t ctl_out
);

	pmc_state_t s_q;
	pmc_state_t s_d;
	logic wr_go;
	logic [32:0] rdw;
	logic [8:0] lim;

	////////////////////////////////////////////////////////////////////////////////
	// register read mux

	function automatic logic [32:0] rd_word(input logic [7:0] a, input pmc_state_t s);
		logic [32:0] r;
		r = 33'h0;
		case (a)
			`PMC_CTRL_OFS: begin
				r[`PMC_CTRL_IDLE_BIT] = s.idle;
				r[`PMC_CTRL_DOZE_BIT] = s.doze;
				r[`PMC_CTRL_ROI_BIT] = s.recover_on_interrupt;
				r[`PMC_CTRL_DOE_BIT] = s.doze_on_exit;
				r[2:0] = s.ratio;
			end
			`PMC_VREG_OFS: begin
				r[`PMC_VREG_LP_BIT] = s.vreg;
				r[`PMC_VREG_ONE_BIT] = 1'b1;
			end
			`PMC_STAT_OFS: begin
				r[`PMC_STAT_TO_BIT] = s.to;
				r[`PMC_STAT_PD_BIT] = s.pd;
				r[2:0] = s.st;
			end
			`PMC_CFG_OFS: begin
				r[`PMC_CFG_XTAL_BIT] = s.xtal;
				r[`PMC_CFG_WSLP_BIT] = s.wdt_slp;
			end
			default: begin
				r[32] = 1'b1;
			end
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_d = s_q;
		rdw = rd_word(axi_in.araddr, s_q);
		s_d.ctl.wdt_clear = 1'b0;
		s_d.ctl.wdt_reset = 1'b0;
		s_d.ctl.prefetch = 1'b0;
		s_d.ctl.vector_req = 1'b0;
		s_d.ctl.resume = 1'b0;

		// write address and data, either order
		if (axi_in.awvalid && s_q.axo.awready) begin
			s_d.aw_have = 1'b1;
			s_d.aw_addr = axi_in.awaddr;
		end
		if (axi_in.wvalid && s_q.axo.wready) begin
			s_d.w_have = 1'b1;
			s_d.w_data = axi_in.wdata[7:0];
			s_d.w_strb0 = axi_in.wstrb[0];
		end
		if (s_q.axo.bvalid && axi_in.bready) begin
			s_d.axo.bvalid = 1'b0;
		end
		wr_go = s_q.aw_have && s_q.w_have && !s_q.axo.bvalid;
		if (wr_go) begin
			s_d.aw_have = 1'b0;
			s_d.w_have = 1'b0;
			s_d.axo.bvalid = 1'b1;
			s_d.axo.bresp = `PMC_RESP_OKAY;
			case (s_q.aw_addr)
				`PMC_CTRL_OFS: begin
					if (s_q.w_strb0) begin
						s_d.idle = s_q.w_data[`PMC_CTRL_IDLE_BIT];
						s_d.doze = s_q.w_data[`PMC_CTRL_DOZE_BIT];
						s_d.recover_on_interrupt = s_q.w_data[`PMC_CTRL_ROI_BIT];
						s_d.doze_on_exit = s_q.w_data[`PMC_CTRL_DOE_BIT];
						s_d.ratio = s_q.w_data[2:0];
					end
				end
				`PMC_VREG_OFS: begin
					if (s_q.w_strb0) begin
						s_d.vreg = s_q.w_data[`PMC_VREG_LP_BIT];
					end
				end
				`PMC_STAT_OFS: begin
					s_d.axo.bresp = `PMC_RESP_OKAY;
				end
				`PMC_CFG_OFS: begin
					if (s_q.w_strb0) begin
						s_d.xtal = s_q.w_data[`PMC_CFG_XTAL_BIT];
						s_d.wdt_slp = s_q.w_data[`PMC_CFG_WSLP_BIT];
					end
				end
				default: begin
					s_d.axo.bresp = `PMC_RESP_SLVERR;
				end
			endcase
		end

		// read channel
		if (s_q.axo.rvalid && axi_in.rready) begin
			s_d.axo.rvalid = 1'b0;
		end
		if (axi_in.arvalid && s_q.axo.arready) begin
			s_d.axo.rvalid = 1'b1;
			s_d.axo.rdata = rdw[31:0];
			s_d.axo.rresp = rdw[32] ? `PMC_RESP_SLVERR : `PMC_RESP_OKAY;
		end

		// interrupt entry and return override a same-cycle write
		if (cpu_in.isr_entry) begin
			s_d.doze_on_exit = s_q.doze;
			if (s_q.recover_on_interrupt) begin
				s_d.doze = 1'b0;
			end
		end
		if (cpu_in.isr_return) begin
			s_d.doze = s_q.doze_on_exit;
		end

		case (s_q.st)
			PMC_RUN: begin
				if (cpu_in.wdt_timeout) begin
					s_d.ctl.wdt_reset = 1'b1;
				end
				if (cpu_in.sleep_exec && s_q.ctl.cpu_run) begin
					if (!(cpu_in.int_pending && !cpu_in.global_int_enable)) begin
						s_d.ctl.prefetch = 1'b1;
						s_d.ctl.wdt_clear = 1'b1;
						s_d.pd = 1'b0;
						s_d.to = 1'b1;
						s_d.wake_int = 1'b0;
						s_d.st = s_q.idle ? PMC_IDLE : PMC_SLEEP;
					end
				end
			end
			PMC_IDLE: begin
				if (cpu_in.int_pending) begin
					s_d.st = PMC_RUN;
					s_d.wake_int = 1'b1;
					if (s_q.recover_on_interrupt) begin
						s_d.doze = 1'b0;
					end
				end else if (cpu_in.wdt_timeout) begin
					s_d.st = PMC_RUN;
				end
			end
			PMC_SLEEP: begin
				if (cpu_in.int_pending || (cpu_in.wdt_timeout && s_q.wdt_slp)) begin
					s_d.ctl.wdt_clear = 1'b1;
					s_d.wake_int = cpu_in.int_pending;
					s_d.wcnt = 12'h000;
					if (s_q.xtal) begin
						s_d.st = PMC_OST;
					end else if (s_q.vreg) begin
						s_d.st = PMC_STAB;
					end else begin
						s_d.st = PMC_RUN;
					end
				end
			end
			PMC_OST: begin
				s_d.wcnt = 12'(s_q.wcnt + 12'h001);
				if (s_q.wcnt == 12'(`PMC_OST_CYC - 1)) begin
					s_d.wcnt = 12'h000;
					s_d.st = s_q.vreg ? PMC_STAB : PMC_RUN;
				end
			end
			PMC_STAB: begin
				s_d.wcnt = 12'(s_q.wcnt + 12'h001);
				if (s_q.wcnt == 12'(`PMC_VREG_STAB_CYC - 1)) begin
					s_d.wcnt = 12'h000;
					s_d.st = PMC_RUN;
				end
			end
			default: begin
				s_d.st = PMC_RUN;
			end
		endcase

		// wake completes: continue in line or vector
		if (s_d.st == PMC_RUN && s_q.st != PMC_RUN) begin
			s_d.ctl.resume = 1'b1;
			s_d.ctl.vector_req = s_d.wake_int && cpu_in.global_int_enable;
		end

		// doze cycle counter
		lim = 9'(9'h002 << s_d.ratio) - 9'h001;
		if (s_d.doze != s_q.doze || s_d.ratio != s_q.ratio || s_d.st != PMC_RUN) begin
			s_d.cnt = 8'h00;
		end else if (s_q.doze) begin
			s_d.cnt = ({1'b0, s_q.cnt} == lim) ? 8'h00 : 8'(s_q.cnt + 8'h01);
		end

		s_d.ctl.cpu_run = s_d.st == PMC_RUN && (!s_d.doze || s_d.cnt == 8'h00);
		s_d.ctl.sys_clk_en = s_d.st == PMC_RUN || s_d.st == PMC_IDLE;
		s_d.ctl.slow_osc_en = 1'b1;
		s_d.ctl.io_hold = s_d.st == PMC_SLEEP;
		s_d.ctl.reg_low_power = s_d.vreg && s_d.st == PMC_SLEEP;
		s_d.ctl.wdt_run = s_d.st != PMC_SLEEP || s_d.wdt_slp;

		s_d.axo.awready = !s_d.aw_have && !s_d.axo.bvalid;
		s_d.axo.wready = !s_d.w_have && !s_d.axo.bvalid;
		s_d.axo.arready = !s_d.axo.rvalid;
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register; only rst_in resets it here, a watchdog timeout in run just raises wdt_reset

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			s_q <= '0;
			s_q.st <= PMC_RUN;
			s_q.pd <= 1'b1;
			s_q.to <= 1'b1;
			s_q.ctl.cpu_run <= 1'b1;
			s_q.ctl.sys_clk_en <= 1'b1;
			s_q.ctl.slow_osc_en <= 1'b1;
			s_q.ctl.wdt_run <= 1'b1;
			s_q.axo.awready <= 1'b1;
			s_q.axo.wready <= 1'b1;
			s_q.axo.arready <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign axi_out = s_q.axo;
	assign ctl_out = s_q.ctl;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (rst_in);

	doze_cycle_a: assert property (
		(s_q.st == PMC_RUN && s_q.doze && s_q.ctl.cpu_run) |-> s_q.cnt == 8'h00)
		else $error("cpu runs off the doze slot");

	periph_clock_a: assert property (
		(s_q.st == PMC_RUN || s_q.st == PMC_IDLE) |-> s_q.ctl.sys_clk_en)
		else $error("system clock gated while awake");

	isr_copy_a: assert property (
		(cpu_in.isr_entry && !cpu_in.isr_return) |=> s_q.doze_on_exit == $past(s_q.doze))
		else $error("doze_on_exit not copied on isr entry");

	roi_clear_a: assert property (
		(cpu_in.isr_entry && s_q.recover_on_interrupt && !cpu_in.isr_return) |=> !s_q.doze)
		else $error("doze not cleared by recover on interrupt");

	isr_exit_a: assert property (
		cpu_in.isr_return |=> s_q.doze == $past(s_q.doze_on_exit))
		else $error("doze not restored from doze_on_exit");

	sleep_flags_a: assert property (
		(s_q.st == PMC_RUN && s_d.st == PMC_SLEEP) |=> (!s_q.pd && s_q.to && s_q.ctl.wdt_clear
		&& s_q.ctl.io_hold))
		else $error("sleep entry flags wrong");

	sleep_nop_a: assert property (
		(s_q.st == PMC_RUN && cpu_in.sleep_exec && cpu_in.int_pending && !cpu_in.global_int_enable)
		|=> (s_q.st == PMC_RUN && $stable(s_q.pd) && $stable(s_q.to) && !s_q.ctl.wdt_clear))
		else $error("sleep not a no-op with interrupt pending");

	idle_wake_a: assert property (
		(s_q.st == PMC_IDLE && cpu_in.int_pending) |=> (s_q.st == PMC_RUN && $stable(s_q.idle)
		&& s_q.ctl.resume))
		else $error("interrupt did not end idle");

	ost_wait_a: assert property (
		$rose(s_q.st == PMC_OST) |-> (s_q.st == PMC_OST && !s_q.ctl.cpu_run)[*8])
		else $error("start-up wait cut short");

	wdt_idle_a: assert property (
		(s_q.st == PMC_IDLE && cpu_in.wdt_timeout && !cpu_in.int_pending) |=> (s_q.st == PMC_RUN
		&& !s_q.ctl.wdt_reset && $stable(s_q.doze)))
		else $error("watchdog in idle mishandled");

endmodule

// file: pmc_cpu_model.sv
`timescale 1ns/1ps
module pmc_cpu_model import pmc_pkg::*; (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire pmc_ctl_out_t ctl_in,
	input wire logic [2:0] op_in,
	input wire logic irq_in,
	input wire logic gie_in,
	output pmc_cpu_in_t cpu_out
);
	logic pend_q;
	// sleep waits for an executing cycle
	always_ff @(posedge clk_in) begin
		if (rst_in)
			pend_q <= 1'b0;
		else if (op_in == 3'h1)
			pend_q <= 1'b1;
		else if (ctl_in.cpu_run)
			pend_q <= 1'b0;
	end
	assign cpu_out.sleep_exec = pend_q & ctl_in.cpu_run;
	assign cpu_out.isr_entry = (op_in == 3'h2);
	assign cpu_out.isr_return = (op_in == 3'h3);
	assign cpu_out.wdt_timeout = (op_in == 3'h4);
	assign cpu_out.int_pending = irq_in;
	assign cpu_out.global_int_enable = gie_in;
endmodule

// file: tb.sv
`timescale 1ns/1ps
module tb;
	import pmc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	pmc_axi_in_t ai = '0;
	pmc_axi_out_t ao;
	pmc_cpu_in_t ci;
	pmc_ctl_out_t co;
	logic [2:0] op = 3'h0;
	logic irq = 1'b0;
	logic global_int_enable = 1'b0;
	int error_cnt = 0;
	int n_checks = 0;
	logic [31:0] rd;
	logic [1:0] rs;
	logic v;
	logic w;
	int n;
	always #5 clk = ~clk;
	pmc_top pmc_top_inst (.ref_clk_in(clk), .rst_in(rst), .axi_in(ai), .axi_out(ao),
		.cpu_in(ci), .ctl_out(co));
	pmc_cpu_model pmc_cpu_model_inst (.clk_in(clk), .rst_in(rst), .ctl_in(co), .op_in(op),
		.irq_in(irq), .gie_in(global_int_enable), .cpu_out(ci));
	////////////////////////////////////////////////////////////////
	task print_verdict;
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task tmo(input int i, input int lim);
		if (i == lim) begin
			error_cnt++;
			print_verdict;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		ai.awvalid <= 1'b1;
		ai.awaddr <= a;
		ai.wvalid <= 1'b1;
		ai.wdata <= d;
		ai.wstrb <= 4'hF;
		ai.bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (ao.awready)
				ai.awvalid <= 1'b0;
			if (ao.wready)
				ai.wvalid <= 1'b0;
			if (ao.bvalid)
				break;
		end
		rs = ao.bresp;
		ai.bready <= 1'b0;
		tmo(i, 50);
	endtask
	task rc(input logic [7:0] a, input logic [31:0] e);
		int i;
		@(posedge clk);
		ai.arvalid <= 1'b1;
		ai.araddr <= a;
		ai.rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (ao.arready)
				ai.arvalid <= 1'b0;
			if (ao.rvalid)
				break;
		end
		rd = ao.rdata;
		rs = ao.rresp;
		ai.rready <= 1'b0;
		tmo(i, 50);
		chk(rd, e);
	endtask
	task cpu_op(input logic [2:0] o);
		@(posedge clk);
		op <= o;
		@(posedge clk);
		op <= 3'h0;
		repeat (3) @(posedge clk);
	endtask
	task wake(input logic g);
		int i;
		@(posedge clk);
		global_int_enable <= g;
		irq <= 1'b1;
		w = 1'b0;
		for (i = 0; i < 2000; i++) begin
			@(posedge clk);
			w = w | co.wdt_clear;
			if (co.resume)
				break;
		end
		n = i;
		v = co.vector_req;
		irq <= 1'b0;
		tmo(i, 2000);
	endtask
	////////////////////////////////////////////////////////////////
	task doze_t;
		int r;
		int i;
		int c;
		int s;
		for (r = 0; r < 8; r++) begin
			wr(8'h00, 32'h40 | r);
			repeat (4) @(posedge clk);
			c = 0;
			s = 0;
			for (i = 0; i < 256; i++) begin
				@(posedge clk);
				c += co.cpu_run;
				s += co.sys_clk_en;
			end
			chk(c, 256 >> (r + 1));
			chk(s, 256);
		end
	endtask
	task isr_t;
		wr(8'h00, 32'h40);
		cpu_op(3'h2);
		rc(8'h00, 32'h50);
		wr(8'h00, 32'h40);
		cpu_op(3'h3);
		rc(8'h00, 32'h00);
		wr(8'h00, 32'h60);
		cpu_op(3'h2);
		rc(8'h00, 32'h30);
		cpu_op(3'h3);
		rc(8'h00, 32'h70);
	endtask
	task noop_t;
		wr(8'h00, 32'h0);
		irq <= 1'b1;
		cpu_op(3'h1);
		rc(8'h08, 32'h18);
		irq <= 1'b0;
	endtask
	task sleep_t;
		wr(8'h04, 32'h2);
		rc(8'h04, 32'h3);
		cpu_op(3'h1);
		chk(32'(co.io_hold), 1);
		chk(32'(co.sys_clk_en), 0);
		chk(32'(co.reg_low_power), 1);
		chk(32'(co.slow_osc_en), 1);
		chk(32'(co.wdt_run), 0);
		rc(8'h08, 32'h12);
		wake(1'b1);
		chk(32'(v), 1);
		chk(32'(w), 1);
		wr(8'h04, 32'h0);
		wr(8'h0C, 32'h1);
		cpu_op(3'h1);
		wake(1'b0);
		chk(32'(n >= 1024 && n <= 1030), 1);
		chk(32'(v), 0);
		wr(8'h0C, 32'h0);
	endtask
	task idle_t;
		wr(8'h00, 32'hE0);
		cpu_op(3'h1);
		chk(32'(co.sys_clk_en), 1);
		rc(8'h08, 32'h11);
		cpu_op(3'h4);
		rc(8'h08, 32'h10);
		rc(8'h00, 32'hE0);
		cpu_op(3'h1);
		wake(1'b0);
		rc(8'h00, 32'hA0);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rc(8'h00, 32'h00);
		rc(8'h04, 32'h01);
		rc(8'h08, 32'h18);
		rc(8'h10, 32'h00);
		chk(32'(rs), 2);
		wr(8'h10, 32'h1);
		chk(32'(rs), 2);
		doze_t;
		isr_t;
		noop_t;
		sleep_t;
		idle_t;
		print_verdict;
	end
endmodule
